// ==== shared/ddic_defines.vh ====
// register map, function codes and timing constants for the input command block
// assumes a 32-bit register port with word addresses in bytes
`ifndef DDIC_DEFINES_VH
`define DDIC_DEFINES_VH

// register byte offsets
`define DDIC_REG_CONFIG        8'h00
`define DDIC_REG_KEYPAD_REF    8'h04
`define DDIC_REG_MIN_REF       8'h08
`define DDIC_REG_INPUT_FUNC    8'h0C
`define DDIC_REG_STATUS        8'h10
`define DDIC_REG_OUT_STATUS    8'h14
`define DDIC_REG_POT_REF       8'h18

// config register fields
`define DDIC_CFG_POTINIT_LSB   0
`define DDIC_CFG_PIDEN_BIT     2
`define DDIC_CFG_WIDTH         3
`define DDIC_CFG_RESET         3'h0

// input function register: 6 bits per input, input n at bits 6n+5..6n
`define DDIC_FUNC_BITS         6
`define DDIC_FUNC_RESET        24'h00_0000
`define DDIC_NUM_INPUTS        4
`define DDIC_NUM_OUTPUTS       5
`define DDIC_REF_RESET         16'h0000

// pot init selector values
`define DDIC_POT_FROM_MIN      2'h0
`define DDIC_POT_FROM_LAST     2'h1
`define DDIC_POT_FROM_KEYPAD   2'h2

// input function codes
`define DDIC_FN_NONE           6'h00
`define DDIC_FN_RUN_STOP       6'h01
`define DDIC_FN_GEN_ENABLE     6'h02
`define DDIC_FN_QUICK_STOP     6'h03
`define DDIC_FN_FWD_RUN        6'h04
`define DDIC_FN_REV_RUN        6'h05
`define DDIC_FN_START          6'h06
`define DDIC_FN_STOP           6'h07
`define DDIC_FN_DIRECTION      6'h08
`define DDIC_FN_LOC_REM        6'h09
`define DDIC_FN_POT_UP         6'h0B
`define DDIC_FN_POT_DOWN       6'h0C
`define DDIC_FN_PRESET         6'h0D
`define DDIC_FN_RAMP2          6'h0E
`define DDIC_FN_NO_EXT_ALARM   6'h12
`define DDIC_FN_NO_EXT_FAULT   6'h13
`define DDIC_FN_FAULT_RESET    6'h14
`define DDIC_FN_PID_MAN_AUTO   6'h16
`define DDIC_FN_LOCK_PROG      6'h1A
`define DDIC_FN_LOAD_USER1     6'h1B
`define DDIC_FN_LOAD_USER2     6'h1C
`define DDIC_FN_THERMISTOR     6'h1D
`define DDIC_FN_FWD_RAMP2      6'h23
`define DDIC_FN_REV_RAMP2      6'h24
`define DDIC_FN_POT_UP_ON      6'h25
`define DDIC_FN_POT_DOWN_OFF   6'h26
`define DDIC_FN_RUN_LOCK       6'h33
`define DDIC_FN_FWD_LOCK       6'h34
`define DDIC_FN_REV_LOCK       6'h35

// pot step period
`define DDIC_CLK_MHZ           50
`define DDIC_POT_STEP_US       1000

`endif

// ==== rtl/ddic_sync.v ====
// two-stage synchroniser for a vector of field inputs
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
module ddic_sync #(
   parameter WIDTH = 4
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // data
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;
endmodule // ddic_sync

// ==== rtl/ddic_edge.v ====
// edge detector for already synchronised levels
// assumes inputs are synchronous to clk
`timescale 1ns/1ps
module ddic_edge #(
   parameter WIDTH = 4
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // levels and edges
   input  wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] change
);
   reg [WIDTH-1:0] prev_q;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         prev_q <= {WIDTH{1'b0}};
      else
         prev_q <= level;
   end

   assign rise   = level & ~prev_q;
   assign change = level ^ prev_q;
endmodule // ddic_edge

// ==== rtl/ddic_top.v ====
// digital input command decoder for a motor drive
// assumes inputs synchronous per settings, one 50 MHz clock, plain register port
// Notes on behaviour
// - run/stop input active runs on accel ramp, inactive stops on decel ramp.
// - general enable active runs; inactive cuts switching pulses at once, motor coasts.
// - quick stop inactive stops the drive on the third ramp time.
// - forward and reverse run are run/stop with a fixed direction.
// - three-wire: start pulse latches run, held only while stop input active.
// - rotation refused unless all enable, quick stop, stop inputs active, start too unless three-wire latched.
// - direction input inactive gives clockwise, active counterclockwise.
// - local/remote input inactive selects local, active selects remote.
// - pot reference start value from minimum, last value, or keypad per selector.
// - both pot inputs active while disabled resets the pot reference.
// - up to three preset inputs form a binary index of eight presets.
// - ramp select input inactive gives first ramp pair, active second.
// - no-external-alarm input inactive raises the external alarm.
// - no-external-fault inactive raises external fault and cuts pulses immediately.
// - fault reset transition clears fault only when its cause has gone.
// - with PID enabled, man/auto picks manual reference or PID output.
// - program lock input active rejects every parameter write.
// - transition on load-user input while drive not running loads that stored user set.
// - thermistor function on the second input forces configuration status.
// - power-up-locked run ignores input active at power-up until re-raised.
// - pot up pulse turns drive on, pot down pulse turns off at minimum.
// - output status word shows outputs one to five in bits 0 to 4.
`timescale 1ns/1ps
`include "ddic_defines.vh"
module ddic_top #(
   parameter POT_STEP_CYCLES = `DDIC_POT_STEP_US * `DDIC_CLK_MHZ
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // register port
   input  wire [7:0]  regAddr,
   input  wire [31:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdData,
   // field inputs and output line states
   input  wire [3:0]  digitalInputN,
   input  wire [4:0]  outputLines,
   // drive state from outside
   input  wire        faultCause,
   input  wire        speedAtMin,
   input  wire [15:0] pidOutput,
   input  wire [15:0] localRef,
   // drive commands
   output reg         runCmd,
   output reg         pulseEnable,
   output reg         coastStop,
   output reg         quickStopRamp,
   output reg         dirCcw,
   output reg         remoteSel,
   output reg         secondRamp,
   output reg  [2:0]  presetIndex,
   output reg  [15:0] speedRef,
   output reg  [15:0] potRef,
   // alarms, faults, status
   output reg         extAlarm,
   output reg         extFault,
   output reg         faultActive,
   output reg         paramLock,
   output reg         configurationStatus,
   output reg         loadUser1,
   output reg         loadUser2
);
   // registers
   reg  [`DDIC_CFG_WIDTH-1:0] config_q;
   reg  [15:0]                keypadRef_q;
   reg  [15:0]                minRef_q;
   reg  [23:0]                inputFunc_q;
   reg  [4:0]                 outStatus_q;
   reg  [15:0]                potRef_q;
   reg  [15:0]                potRef_d;
   reg                        faultActive_q;
   reg                        threeWire_q;
   reg                        potOn_q;
   reg                        runPrev_q;
   reg  [3:0]                 armed_q;
   reg  [1:0]                 settle_q;
   reg  [15:0]                stepCnt_q;
   reg                        stepTick;

   wire [3:0]  diLevel;
   wire [3:0]  diRise;
   wire [3:0]  diChange;

   // synchronise and edge-detect inputs
   ddic_sync #(
      .WIDTH   (`DDIC_NUM_INPUTS)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .asyncIn (digitalInputN),
      .syncOut (diLevel)
   );

   ddic_edge #(
      .WIDTH   (`DDIC_NUM_INPUTS)
   ) u_edge (
      .clk     (clk),
      .reset_n (reset_n),
      .level   (diLevel),
      .rise    (diRise),
      .change  (diChange)
   );

   // mask of inputs that carry a given function code
   function [3:0] assigned;
      input [23:0] funcs;
      input [5:0]  code;
      integer      k;
      begin
         assigned = 4'h0;
         for (k = 0; k < 4; k = k + 1)
            assigned[k] = (funcs[k*6 +: 6] == code);
      end
   endfunction

   wire [3:0] mRun      = assigned(inputFunc_q, `DDIC_FN_RUN_STOP);
   wire [3:0] mGe       = assigned(inputFunc_q, `DDIC_FN_GEN_ENABLE);
   wire [3:0] mQs       = assigned(inputFunc_q, `DDIC_FN_QUICK_STOP);
   wire [3:0] mFwd      = assigned(inputFunc_q, `DDIC_FN_FWD_RUN)
                        | assigned(inputFunc_q, `DDIC_FN_FWD_RAMP2);
   wire [3:0] mRev      = assigned(inputFunc_q, `DDIC_FN_REV_RUN)
                        | assigned(inputFunc_q, `DDIC_FN_REV_RAMP2);
   wire [3:0] mStart    = assigned(inputFunc_q, `DDIC_FN_START);
   wire [3:0] mStop     = assigned(inputFunc_q, `DDIC_FN_STOP);
   wire [3:0] mDir      = assigned(inputFunc_q, `DDIC_FN_DIRECTION);
   wire [3:0] mLocRem   = assigned(inputFunc_q, `DDIC_FN_LOC_REM);
   wire [3:0] mUp       = assigned(inputFunc_q, `DDIC_FN_POT_UP);
   wire [3:0] mDown     = assigned(inputFunc_q, `DDIC_FN_POT_DOWN);
   wire [3:0] mUpOn     = assigned(inputFunc_q, `DDIC_FN_POT_UP_ON);
   wire [3:0] mDownOff  = assigned(inputFunc_q, `DDIC_FN_POT_DOWN_OFF);
   wire [3:0] mPreset   = assigned(inputFunc_q, `DDIC_FN_PRESET);
   wire [3:0] mRamp2    = assigned(inputFunc_q, `DDIC_FN_RAMP2)
                        | assigned(inputFunc_q, `DDIC_FN_FWD_RAMP2)
                        | assigned(inputFunc_q, `DDIC_FN_REV_RAMP2);
   wire [3:0] mAlarm    = assigned(inputFunc_q, `DDIC_FN_NO_EXT_ALARM);
   wire [3:0] mFault    = assigned(inputFunc_q, `DDIC_FN_NO_EXT_FAULT);
   wire [3:0] mReset    = assigned(inputFunc_q, `DDIC_FN_FAULT_RESET);
   wire [3:0] mManAuto  = assigned(inputFunc_q, `DDIC_FN_PID_MAN_AUTO);
   wire [3:0] mLock     = assigned(inputFunc_q, `DDIC_FN_LOCK_PROG);
   wire [3:0] mUser1    = assigned(inputFunc_q, `DDIC_FN_LOAD_USER1);
   wire [3:0] mUser2    = assigned(inputFunc_q, `DDIC_FN_LOAD_USER2);
   wire [3:0] mRunLk    = assigned(inputFunc_q, `DDIC_FN_RUN_LOCK);
   wire [3:0] mFwdLk    = assigned(inputFunc_q, `DDIC_FN_FWD_LOCK);
   wire [3:0] mRevLk    = assigned(inputFunc_q, `DDIC_FN_REV_LOCK);

   // locked run inputs count only once re-armed
   wire [3:0] lockLevel = diLevel & armed_q;
   wire [3:0] mAnyLk    = mRunLk | mFwdLk | mRevLk;

   wire fwdAct   = |((mFwd & diLevel) | (mFwdLk & lockLevel));
   wire revAct   = |((mRev & diLevel) | (mRevLk & lockLevel));
   wire runAct   = |(mRun & diLevel) | |(mRunLk & lockLevel);
   wire stopAct  = ((mStop & diLevel) == mStop);
   wire hasRun   = |(mRun | mFwd | mRev | mStart | mAnyLk | mUpOn);

   // enable, quick stop and stop inputs must be active; start too unless three-wire latched
   wire gateOk   = ((mGe & diLevel) == mGe)
                 & ((mQs & diLevel) == mQs)
                 & ((mStart & diLevel) == mStart | threeWire_q)
                 & stopAct;
   wire fwdRevOk = ~(|(mFwd | mRev)) | fwdAct | revAct;

   wire geInactive  = |(mGe & ~diLevel);
   wire qsInactive  = |(mQs & ~diLevel);
   wire faultIn     = |(mFault & ~diLevel);
   wire upAct       = |((mUp | mUpOn) & diLevel);
   wire downAct     = |((mDown | mDownOff) & diLevel);
   wire pidEnable   = config_q[`DDIC_CFG_PIDEN_BIT];
   wire [1:0] potInitSel = config_q[`DDIC_CFG_POTINIT_LSB +: 2];
   wire runReq      = hasRun & gateOk & fwdRevOk
                    & (runAct | fwdAct | revAct | threeWire_q | potOn_q);
   wire runGo       = runReq & ~faultActive_q & ~faultIn;
   wire wrAllowed   = ~(|(mLock & diLevel));

   // pot step divider
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stepCnt_q <= 16'h0000;
         stepTick  <= 1'b0;
      end
      else if (stepCnt_q == POT_STEP_CYCLES[15:0] - 16'h0001)
      begin
         stepCnt_q <= 16'h0000;
         stepTick  <= 1'b1;
      end
      else
      begin
         stepCnt_q <= stepCnt_q + 16'h0001;
         stepTick  <= 1'b0;
      end
   end

   // register writes
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         config_q    <= `DDIC_CFG_RESET;
         keypadRef_q <= `DDIC_REF_RESET;
         minRef_q    <= `DDIC_REF_RESET;
         inputFunc_q <= `DDIC_FUNC_RESET;
      end
      else if (regWr && wrAllowed)
      begin
         case (regAddr)
            `DDIC_REG_CONFIG:     config_q    <= regWrData[`DDIC_CFG_WIDTH-1:0];
            `DDIC_REG_KEYPAD_REF: keypadRef_q <= regWrData[15:0];
            `DDIC_REG_MIN_REF:    minRef_q    <= regWrData[15:0];
            `DDIC_REG_INPUT_FUNC: inputFunc_q <= regWrData[23:0];
            default:              config_q    <= config_q;
         endcase
      end
   end

   // run-latch state: three-wire, pot turn-on, power-up arming
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         threeWire_q <= 1'b0;
         potOn_q     <= 1'b0;
         armed_q     <= 4'h0;
         settle_q    <= 2'h0;
         runPrev_q   <= 1'b0;
      end
      else
      begin
         runPrev_q <= runGo;
         if (settle_q != 2'h3)
            settle_q <= settle_q + 2'h1;
         else
            armed_q <= armed_q | ~diLevel;
         if (!stopAct)
            threeWire_q <= 1'b0;
         else if (|(mStart & diRise))
            threeWire_q <= 1'b1;
         if (|(mUpOn & diRise))
            potOn_q <= 1'b1;
         else if (|(mDownOff & diRise) && speedAtMin)
            potOn_q <= 1'b0;
      end
   end

   // pot reference
   always @*
   begin
      potRef_d = potRef_q;
      if (runGo && !runPrev_q)
      begin
         case (potInitSel)
            `DDIC_POT_FROM_MIN:    potRef_d = minRef_q;
            `DDIC_POT_FROM_LAST:   potRef_d = potRef_q;
            `DDIC_POT_FROM_KEYPAD: potRef_d = keypadRef_q;
            default:               potRef_d = minRef_q;
         endcase
      end
      else if (!runGo && upAct && downAct)
         potRef_d = minRef_q;
      else if (runGo && stepTick && upAct && !downAct && potRef_q != 16'hFFFF)
         potRef_d = potRef_q + 16'h0001;
      else if (runGo && stepTick && downAct && !upAct && potRef_q > minRef_q)
         potRef_d = potRef_q - 16'h0001;
   end

   // fault state: new fault wins over reset
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         potRef_q      <= `DDIC_REF_RESET;
         faultActive_q <= 1'b0;
      end
      else
      begin
         potRef_q <= potRef_d;
         if (faultIn || faultCause)
            faultActive_q <= 1'b1;
         else if (faultActive_q && |(mReset & diChange))
            faultActive_q <= 1'b0;
      end
   end

   // command outputs
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         runCmd              <= 1'b0;
         pulseEnable         <= 1'b0;
         coastStop           <= 1'b0;
         quickStopRamp       <= 1'b0;
         dirCcw              <= 1'b0;
         remoteSel           <= 1'b0;
         secondRamp          <= 1'b0;
         presetIndex         <= 3'h0;
         speedRef            <= 16'h0000;
         potRef              <= 16'h0000;
         extAlarm            <= 1'b0;
         extFault            <= 1'b0;
         faultActive         <= 1'b0;
         paramLock           <= 1'b0;
         configurationStatus <= 1'b0;
         loadUser1           <= 1'b0;
         loadUser2           <= 1'b0;
      end
      else
      begin
         runCmd        <= runGo;
         coastStop     <= geInactive | faultIn;
         pulseEnable   <= runGo & ~geInactive & ~faultIn & ~qsInactive;
         quickStopRamp <= qsInactive;
         if (fwdAct)
            dirCcw <= 1'b0;
         else if (revAct)
            dirCcw <= 1'b1;
         else
            dirCcw <= |(mDir & diLevel);
         remoteSel     <= |(mLocRem & diLevel);
         secondRamp    <= |(mRamp2 & diLevel);
         presetIndex   <= presetBits(mPreset, diLevel);
         if (pidEnable && |(mManAuto & diLevel))
            speedRef <= pidOutput;
         else if (pidEnable && |mManAuto)
            speedRef <= localRef;
         else
            speedRef <= potRef_q;
         potRef        <= potRef_q;
         extAlarm      <= |(mAlarm & ~diLevel);
         extFault      <= faultIn;
         faultActive   <= faultActive_q;
         paramLock     <= ~wrAllowed;
         configurationStatus <= (inputFunc_q[11:6] == `DDIC_FN_THERMISTOR);
         loadUser1     <= ~runGo & |(mUser1 & diChange);
         loadUser2     <= ~runGo & |(mUser2 & diChange);
      end
   end

   // preset index: assigned inputs fill bits in input order
   function [2:0] presetBits;
      input [3:0] mask;
      input [3:0] lvl;
      integer     k;
      integer     n;
      begin
         presetBits = 3'h0;
         n = 0;
         for (k = 0; k < 4; k = k + 1)
         begin
            if (mask[k] && n < 3)
            begin
               presetBits[n] = lvl[k];
               n = n + 1;
            end
         end
      end
   endfunction

   // output line capture
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         outStatus_q <= 5'h00;
      else
         outStatus_q <= outputLines;
   end

   // register reads, data one cycle after strobe
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         regRdData <= 32'h0000_0000;
      else if (regRd)
      begin
         case (regAddr)
            `DDIC_REG_CONFIG:     regRdData <= {29'h0, config_q};
            `DDIC_REG_KEYPAD_REF: regRdData <= {16'h0000, keypadRef_q};
            `DDIC_REG_MIN_REF:    regRdData <= {16'h0000, minRef_q};
            `DDIC_REG_INPUT_FUNC: regRdData <= {8'h00, inputFunc_q};
            `DDIC_REG_STATUS:     regRdData <= {20'h0_0000, configurationStatus,
                                                paramLock, faultActive_q, extFault,
                                                extAlarm, dirCcw, runCmd, pulseEnable,
                                                diLevel};
            `DDIC_REG_OUT_STATUS: regRdData <= {27'h000_0000, outStatus_q};
            `DDIC_REG_POT_REF:    regRdData <= {16'h0000, potRef_q};
            default:              regRdData <= 32'h0000_0000;
         endcase
      end
      else
         regRdData <= 32'h0000_0000;
   end
endmodule // ddic_top

// ==== verif/ddic_checker.sv ====
// port assertions for the input command block
// assumes bind to ddic_top, one clock, async active-low reset
`timescale 1ns/1ps
module ddic_checker (
   // clock and reset
   input wire        clk,
   input wire        reset_n,
   // register port
   input wire [7:0]  regAddr,
   input wire        regRd,
   input wire [31:0] regRdData,
   input wire [4:0]  outputLines,
   // commands
   input wire        runCmd,
   input wire        pulseEnable,
   input wire        coastStop,
   input wire        extFault,
   input wire        faultActive,
   input wire        loadUser1,
   input wire        loadUser2
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence sOutRead;
      regRd && regAddr == 8'h14 && $stable(outputLines);
   endsequence
   sequence sFaultHeld;
      faultActive [*2];
   endsequence
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
      else $error("read data not zero outside a read");
   AST_RD_OUT: assert property (sOutRead |=> regRdData == {27'h0, $past(outputLines)})
      else $error("output status read wrong");
   AST_RD_UNMAPPED: assert property (regRd && regAddr > 8'h18 |=> regRdData == 0)
      else $error("unmapped read not zero");
   AST_USER1_PULSE: assert property (loadUser1 |=> !loadUser1)
      else $error("load user 1 longer than a cycle");
   AST_USER2_PULSE: assert property (loadUser2 |=> !loadUser2)
      else $error("load user 2 longer than a cycle");
   AST_FAULT_LATCH: assert property (extFault |=> faultActive)
      else $error("external fault not latched");
   AST_FAULT_NO_RUN: assert property (sFaultHeld |-> !runCmd)
      else $error("run while fault active");
   AST_RUN_PULSES: assert property (runCmd |-> pulseEnable)
      else $error("run without pulses");
   AST_COAST: assert property (coastStop |-> !pulseEnable)
      else $error("pulses on during coast stop");
endmodule // ddic_checker
bind ddic_top ddic_checker u_chk (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
   .regRd(regRd), .regRdData(regRdData), .outputLines(outputLines), .runCmd(runCmd),
   .pulseEnable(pulseEnable), .coastStop(coastStop), .extFault(extFault),
   .faultActive(faultActive), .loadUser1(loadUser1), .loadUser2(loadUser2));

// ==== verif/ddic_field_model.sv ====
// field contacts on the digital inputs, set from wanted levels
// assumes want changes after a rising edge; slow adds contact delay
`timescale 1ns/1ps
module ddic_field_model (
   // clock
   input  wire       clk,
   // wanted contact states
   input  wire [3:0] want,
   input  wire       slow,
   // contacts
   output reg  [3:0] digitalInputN
);
   reg [1:0] lagQ = 2'h0;
   initial digitalInputN = 4'h0;
   always @(posedge clk)
   begin
      lagQ <= lagQ + 2'h1;
      if (!slow || lagQ == 2'h3)
         digitalInputN <= want;
   end
endmodule // ddic_field_model

// ==== verif/tb_drive_digital_input_commands.sv ====
// self-checking bench for the input command block
// assumes ddic_top with a short pot step, field model on the inputs
`timescale 1ns/1ps
module tb_drive_digital_input_commands;
   logic        clk, reset_n = 0, regWr = 0, regRd = 0, slow = 0, faultCause = 0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic [3:0]  want = 4'h0;
   logic [4:0]  outputLines = 5'h00;
   logic [15:0] pidOutput = 16'h0ABC, localRef = 16'h0321;
   wire  [31:0] regRdData;
   wire  [3:0]  digitalInputN;
   wire  [2:0]  presetIndex;
   wire  [15:0] speedRef, potRef;
   wire         runCmd, pulseEnable, coastStop, quickStopRamp, dirCcw, remoteSel, secondRamp;
   wire         extAlarm, extFault, faultActive, paramLock, configurationStatus;
   wire         loadUser1, loadUser2;
   int          checks = 0, fail_count = 0, nUser1 = 0, nUser2 = 0;
   ddic_field_model fm (.clk(clk), .want(want), .slow(slow), .digitalInputN(digitalInputN));
   ddic_top #(.POT_STEP_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .digitalInputN(digitalInputN), .outputLines(outputLines), .faultCause(faultCause),
      .speedAtMin(1'b0), .pidOutput(pidOutput), .localRef(localRef), .runCmd(runCmd),
      .pulseEnable(pulseEnable), .coastStop(coastStop), .quickStopRamp(quickStopRamp),
      .dirCcw(dirCcw), .remoteSel(remoteSel), .secondRamp(secondRamp),
      .presetIndex(presetIndex), .speedRef(speedRef), .potRef(potRef), .extAlarm(extAlarm),
      .extFault(extFault), .faultActive(faultActive), .paramLock(paramLock),
      .configurationStatus(configurationStatus), .loadUser1(loadUser1), .loadUser2(loadUser2));
   initial
   begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (loadUser1 === 1'b1) nUser1++;
      if (loadUser2 === 1'b1) nUser2++;
   end
   function automatic logic [31:0] fw(input logic [5:0] a, b, c, d);
      return {8'h00, d, c, b, a};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // contacts settle within the model lag plus three edges
   task automatic put(input logic [3:0] w);
      @(posedge clk);
      want <= w;
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
   initial
   begin
      logic [31:0] d;
      logic [3:0]  w;
      logic [7:0]  za [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40};
      d = $urandom(60093);
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      foreach (za[i])
      begin
         rd(za[i], d);
         chk("reset value", d, 32'h0000_0000);
      end
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         outputLines <= $urandom;
         wr(8'h14, 32'hFFFF_FFFF);
         rd(8'h14, d);
         chk("output status", d, {27'h0, outputLines});
      end
      $display("test registers done");
      wr(8'h0C, fw(6'h01, 6'h08, 6'h0E, 6'h09));
      for (int i = 0; i < 12; i++)
      begin
         slow = i[0];
         w = (i == 0) ? 4'hF : 4'($urandom);
         put(w);
         chk("run", runCmd, w[0]);
         chk("ccw", dirCcw, w[1]);
         chk("ramp2", secondRamp, w[2]);
         chk("remote", remoteSel, w[3]);
      end
      slow = 0;
      wr(8'h0C, fw(6'h01, 6'h02, 6'h03, 6'h12));
      for (int i = 0; i < 16; i++)
      begin
         put(4'(i));
         chk("gated run", runCmd, &i[2:0]);
         chk("coast", coastStop, !i[1]);
         chk("quick ramp", quickStopRamp, !i[2]);
         chk("alarm", extAlarm, !i[3]);
      end
      wr(8'h0C, fw(6'h04, 6'h05, 6'h00, 6'h00));
      for (int i = 1; i < 3; i++)
      begin
         put(4'(i));
         chk("fwd rev run", runCmd, 1);
         chk("fwd rev dir", dirCcw, i == 2);
      end
      wr(8'h0C, fw(6'h06, 6'h07, 6'h00, 6'h00));
      put(4'h2);
      chk("no start", runCmd, 0);
      put(4'h3);
      put(4'h2);
      chk("start latched", runCmd, 1);
      put(4'h0);
      chk("stop drops", runCmd, 0);
      $display("test commands done");
      wr(8'h0C, fw(6'h0D, 6'h0D, 6'h0D, 6'h00));
      for (int i = 0; i < 8; i++)
      begin
         w = (i == 0) ? 4'h7 : 4'($urandom);
         put(w);
         chk("preset", presetIndex, w[2:0]);
      end
      wr(8'h0C, fw(6'h13, 6'h14, 6'h01, 6'h00));
      faultCause = 1;
      put(4'h4);
      chk("ext fault", extFault, 1);
      chk("fault run", runCmd, 0);
      put(4'h5);
      put(4'h7);
      chk("fault kept", faultActive, 1);
      faultCause = 0;
      put(4'h5);
      chk("fault cleared", faultActive, 0);
      wr(8'h0C, fw(6'h1A, 6'h1B, 6'h1C, 6'h00));
      put(4'h1);
      chk("lock", paramLock, 1);
      wr(8'h00, 32'h0000_0005);
      rd(8'h00, d);
      chk("locked write", d, 32'h0000_0000);
      put(4'h2);
      put(4'h4);
      chk("user1 loads", nUser1, 2);
      chk("user2 loads", nUser2, 2);
      wr(8'h04, 32'h0000_0123);
      wr(8'h08, 32'h0000_0040);
      wr(8'h0C, fw(6'h01, 6'h00, 6'h00, 6'h00));
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h00, 32'(i));
         put(4'h1);
         chk("pot start", potRef, (i == 2) ? 16'h0123 : 16'h0040);
         put(4'h0);
      end
      wr(8'h00, 32'h0000_0004);
      wr(8'h0C, fw(6'h16, 6'h00, 6'h00, 6'h00));
      put(4'h1);
      chk("pid auto", speedRef, 16'h0ABC);
      put(4'h0);
      chk("pid manual", speedRef, 16'h0321);
      $display("test fault and pot done");
      @(posedge clk);
      reset_n <= 1'b0;
      want <= 4'h1;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      wr(8'h0C, fw(6'h33, 6'h00, 6'h00, 6'h00));
      put(4'h1);
      chk("power-up locked", runCmd, 0);
      put(4'h0);
      put(4'h1);
      chk("unlocked run", runCmd, 1);
      wr(8'h0C, fw(6'h1D, 6'h00, 6'h00, 6'h1D));
      put(4'h0);
      chk("ptc ok", configurationStatus, 0);
      wr(8'h0C, fw(6'h00, 6'h1D, 6'h00, 6'h00));
      put(4'h0);
      chk("ptc second", configurationStatus, 1);
      $display("test lock and ptc done");
      tally_and_finish();
   end
endmodule // tb_drive_digital_input_commands
